/* File: rtl/s2r_cfg.svh */
`ifndef S2R_CFG_SVH
`define S2R_CFG_SVH

// Register addresses on the configuration port
`define S2R_ADDR_PREDIV     8'h20
`define S2R_ADDR_SRC        8'h21
`define S2R_ADDR_GAIN       8'h28
`define S2R_ADDR_OFFS       8'h29

// Write-select lanes, one per register
`define S2R_NUM_REGS        4
`define S2R_SEL_PREDIV      0
`define S2R_SEL_SRC         1
`define S2R_SEL_GAIN        2
`define S2R_SEL_OFFS        3

// Field positions and widths
`define S2R_DBL_LSB         7
`define S2R_PDIV_LSB        0
`define S2R_PDIV_W          7
`define S2R_VCXO_LSB        7
`define S2R_EXTV_LSB        6
`define S2R_SRC_LSB         4
`define S2R_SRC_W           2
`define S2R_BYP_LSB         3
`define S2R_PD_LSB          7
`define S2R_SINK_LSB        5
`define S2R_X2_LSB          4
`define S2R_GAIN_LSB        0
`define S2R_GAIN_W          4
`define S2R_OFFS_LSB        0
`define S2R_OFFS_W          6

// Reset values
`define S2R_RST_DBL         1'h0
`define S2R_RST_PDIV        7'h01
`define S2R_RST_VCXO        1'h1
`define S2R_RST_EXTV        1'h0
`define S2R_RST_SRC         2'h1
`define S2R_RST_BYP         1'h0
`define S2R_RST_PD          1'h0
`define S2R_RST_SINK        1'h1
`define S2R_RST_X2          1'h1
`define S2R_RST_GAIN        4'h0
`define S2R_RST_OFFS        6'h00

// Divide ratios
`define S2R_RATIO_ONE_7     7'h01
`define S2R_RATIO_ZERO_7    7'h00
`define S2R_RATIO_ONE_2     2'h1
`define S2R_RATIO_TWO_2     2'h2

// Pump currents in 0.1 uA units
`define S2R_STEP_1X_DUA     16'h03E8
`define S2R_STEP_2X_DUA     16'h07D0
`define S2R_BASE_2X_DUA     16'h3E80
`define S2R_OFFS_STEP_DUA   16'h007D

// Offset bit weights in 12.5 uA steps
`define S2R_OFFS_W5         6'h10
`define S2R_OFFS_W4         6'h08
`define S2R_OFFS_W3         6'h08
`define S2R_OFFS_W2         6'h04
`define S2R_OFFS_W1         6'h02
`define S2R_OFFS_W0         6'h01

`define S2R_RD_ZERO         8'h00

`endif

/* File: rtl/s2r_pkg.sv */
package s2r_pkg;

  // Output channel source codes
  typedef enum logic [1:0] {
    S2R_SRC_EXT_VCO   = 2'h0,
    S2R_SRC_LOOP2     = 2'h1,
    S2R_SRC_LOOP1     = 2'h2,
    S2R_SRC_CLK_INPUT = 2'h3
  } s2r_src_t;

  typedef logic [7:0] s2r_byte_t;

endpackage

/* File: rtl/s2r_wr_if.sv */
`timescale 1ns/1ns
`include "s2r_cfg.svh"

// Decoded write path from the port decoder to the field registers
interface s2r_wr_if;
  logic [7:0]                 wdata;
  logic [`S2R_NUM_REGS-1:0]   wr_sel;

  modport ctl (output wdata, output wr_sel);
  modport fld (input wdata, input wr_sel);
endinterface

/* File: rtl/s2r_field.sv */
`timescale 1ns/1ns
`include "s2r_cfg.svh"

// One configuration field: a slice of one register with its own reset value
module s2r_field #(
  parameter int            SEL = 0,
  parameter int            LSB = 0,
  parameter int            W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  s2r_wr_if.fld            wr,
  output logic [W-1:0]     o_q
);

  logic [W-1:0] field_d;

  // Only the field's own bit slice is taken, so reserved bits stay inert
  always_comb begin
    field_d = o_q;
    if (wr.wr_sel[SEL]) begin
      field_d = wr.wdata[LSB +: W];
    end
  end

  // Register with synchronous reset to the documented default
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_q <= RST;
    end else begin
      o_q <= field_d;
    end
  end

endmodule // s2r_field

/* File: rtl/s2r_regs.sv */
`timescale 1ns/1ns
`include "s2r_cfg.svh"
// Notes on behaviour
// - Doubler select 0 feeds loop with bypass mux output over pre-divider.
// - Doubler select 1 doubles the input; pre-divider then has no effect.
// - Seven-bit pre-divider is a plain binary ratio, one to 127.
// - Pre-divider code one bypasses the divider and is the reset value.
// - VCXO halving select 1 (reset) divides VCXO by two before feedback.
// - External VCO halving select 1 halves it; reset value is 0.
// - Source select: ext VCO, loop two (reset), loop one, clock input.
// - Bypass bit 0 is dual loop (reset); 1 bypasses the first loop.
// - Pump power bit 0 keeps pump on (reset); 1 powers it down.
// - Sink enable 1 (reset) enables sink equal to source; 0 disables.
// - Gain double bit picks 100 uA or 200 uA steps; reset is 1.
// - Double off: current is code bits weighted 800, 400, 200, 100 uA.
// - Double on: 1600 uA plus bits two..zero at 800, 400, 200 uA.
// - Six-bit offset sets extra current in 12.5 uA steps, reset zero.
// - Offset bits weigh 200, 100, 100, 50, 25, 12.5 uA, summed.
// - Offset current is added to the stage-two pump output.
module s2r_regs
  import s2r_pkg::*;
(
  input  wire logic         I_CORE_CLK,
  input  wire logic         I_RESET,
  input  wire logic [7:0]   I_REG_ADDR,
  input  wire logic [7:0]   I_REG_WDATA,
  input  wire logic         I_REG_WR,
  input  wire logic         I_REG_RD,
  output logic [7:0]        O_REG_RDATA,
  output logic              O_REG_RVALID,
  output logic              O_INPUT_DOUBLE,
  output logic [6:0]        O_INPUT_DIV_RATIO,
  output logic [1:0]        O_VCXO_FB_DIV_RATIO,
  output logic [1:0]        O_EXT_VCO_DIV_RATIO,
  output logic [1:0]        O_OUTPUT_SOURCE,
  output logic              O_SOURCE_VALID,
  output logic              O_FIRST_LOOP_BYPASS,
  output logic              O_PUMP_ENABLE,
  output logic              O_PUMP_SINK_ENABLE,
  output logic [15:0]       O_PUMP_GAIN_DUA,
  output logic [5:0]        O_PUMP_OFFSET_STEPS,
  output logic [15:0]       O_PUMP_TOTAL_DUA
);

  s2r_wr_if wr ();

  logic                    input_doubler_select;
  logic [`S2R_PDIV_W-1:0]  stage2_predivider;
  logic                    vcxo_feedback_halve_sel;
  logic                    ext_vco_halve_sel;
  logic [`S2R_SRC_W-1:0]   output_source_sel;
  logic                    first_loop_bypass;
  logic                    stage2_pump_powerdown;
  logic                    stage2_pump_sink_enable;
  logic                    stage2_pump_gain_double;
  logic [`S2R_GAIN_W-1:0]  stage2_pump_gain_code;
  logic [`S2R_OFFS_W-1:0]  stage2_pump_offset_code;

  // Write decode: one select lane per mapped address, unmapped writes dropped
  always_comb begin
    wr.wdata  = I_REG_WDATA;
    wr.wr_sel = '0;
    if (I_REG_WR) begin
      case (I_REG_ADDR)
        `S2R_ADDR_PREDIV: wr.wr_sel[`S2R_SEL_PREDIV] = 1'b1;
        `S2R_ADDR_SRC:    wr.wr_sel[`S2R_SEL_SRC]    = 1'b1;
        `S2R_ADDR_GAIN:   wr.wr_sel[`S2R_SEL_GAIN]   = 1'b1;
        `S2R_ADDR_OFFS:   wr.wr_sel[`S2R_SEL_OFFS]   = 1'b1;
        default:          wr.wr_sel = '0;
      endcase
    end
  end

  // Field storage; reserved bit positions have no flops at all
  // Doubler path select, top bit of the pre-divider register
  s2r_field #(
    .SEL (`S2R_SEL_PREDIV),
    .LSB (`S2R_DBL_LSB),
    .W   (1),
    .RST (`S2R_RST_DBL)
  ) u_dbl (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (input_doubler_select)
  );

  // Seven-bit pre-divider code; resets to the bypass code
  s2r_field #(
    .SEL (`S2R_SEL_PREDIV),
    .LSB (`S2R_PDIV_LSB),
    .W   (`S2R_PDIV_W),
    .RST (`S2R_RST_PDIV)
  ) u_pdiv (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_predivider)
  );

  // VCXO feedback halving select, set out of reset
  s2r_field #(
    .SEL (`S2R_SEL_SRC),
    .LSB (`S2R_VCXO_LSB),
    .W   (1),
    .RST (`S2R_RST_VCXO)
  ) u_vcxo (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (vcxo_feedback_halve_sel)
  );

  // External VCO halving select, clear out of reset
  s2r_field #(
    .SEL (`S2R_SEL_SRC),
    .LSB (`S2R_EXTV_LSB),
    .W   (1),
    .RST (`S2R_RST_EXTV)
  ) u_extv (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (ext_vco_halve_sel)
  );

  // Output channel source select
  s2r_field #(
    .SEL (`S2R_SEL_SRC),
    .LSB (`S2R_SRC_LSB),
    .W   (`S2R_SRC_W),
    .RST (`S2R_RST_SRC)
  ) u_src (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (output_source_sel)
  );

  // First-loop bypass mode
  s2r_field #(
    .SEL (`S2R_SEL_SRC),
    .LSB (`S2R_BYP_LSB),
    .W   (1),
    .RST (`S2R_RST_BYP)
  ) u_byp (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (first_loop_bypass)
  );

  // Pump power-down
  s2r_field #(
    .SEL (`S2R_SEL_GAIN),
    .LSB (`S2R_PD_LSB),
    .W   (1),
    .RST (`S2R_RST_PD)
  ) u_pd (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_pump_powerdown)
  );

  // Pump sink current enable
  s2r_field #(
    .SEL (`S2R_SEL_GAIN),
    .LSB (`S2R_SINK_LSB),
    .W   (1),
    .RST (`S2R_RST_SINK)
  ) u_sink (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_pump_sink_enable)
  );

  // Pump gain step doubling
  s2r_field #(
    .SEL (`S2R_SEL_GAIN),
    .LSB (`S2R_X2_LSB),
    .W   (1),
    .RST (`S2R_RST_X2)
  ) u_x2 (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_pump_gain_double)
  );

  // Pump gain code
  s2r_field #(
    .SEL (`S2R_SEL_GAIN),
    .LSB (`S2R_GAIN_LSB),
    .W   (`S2R_GAIN_W),
    .RST (`S2R_RST_GAIN)
  ) u_gain (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_pump_gain_code)
  );

  // Pump offset code; only six bits are kept, so the top two stay inert
  s2r_field #(
    .SEL (`S2R_SEL_OFFS),
    .LSB (`S2R_OFFS_LSB),
    .W   (`S2R_OFFS_W),
    .RST (`S2R_RST_OFFS)
  ) u_offs (
    .i_clk   (I_CORE_CLK),
    .i_reset (I_RESET),
    .wr      (wr),
    .o_q     (stage2_pump_offset_code)
  );

  logic [7:0]  rdata_d;
  logic [7:0]  rdata_q;
  logic        rvalid_q;

  // Read mux; reserved positions and unmapped addresses read as zero
  always_comb begin
    rdata_d = rdata_q;
    if (I_REG_RD) begin
      rdata_d = `S2R_RD_ZERO;
      case (I_REG_ADDR)
        `S2R_ADDR_PREDIV: begin
          rdata_d[`S2R_DBL_LSB]                  = input_doubler_select;
          rdata_d[`S2R_PDIV_LSB +: `S2R_PDIV_W]  = stage2_predivider;
        end
        `S2R_ADDR_SRC: begin
          rdata_d[`S2R_VCXO_LSB]                 = vcxo_feedback_halve_sel;
          rdata_d[`S2R_EXTV_LSB]                 = ext_vco_halve_sel;
          rdata_d[`S2R_SRC_LSB +: `S2R_SRC_W]    = output_source_sel;
          rdata_d[`S2R_BYP_LSB]                  = first_loop_bypass;
        end
        `S2R_ADDR_GAIN: begin
          rdata_d[`S2R_PD_LSB]                   = stage2_pump_powerdown;
          rdata_d[`S2R_SINK_LSB]                 = stage2_pump_sink_enable;
          rdata_d[`S2R_X2_LSB]                   = stage2_pump_gain_double;
          rdata_d[`S2R_GAIN_LSB +: `S2R_GAIN_W]  = stage2_pump_gain_code;
        end
        `S2R_ADDR_OFFS: begin
          rdata_d[`S2R_OFFS_LSB +: `S2R_OFFS_W]  = stage2_pump_offset_code;
        end
        default: rdata_d = `S2R_RD_ZERO;
      endcase
    end
  end

  // Read data holds until the next read so slow hosts can sample it late
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      rdata_q  <= `S2R_RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= I_REG_RD;
    end
  end

  logic [6:0]  in_ratio_d;
  logic [1:0]  vcxo_ratio_d;
  logic [1:0]  extv_ratio_d;
  logic        src_valid_d;
  logic [15:0] gain_d;
  logic [5:0]  offs_d;
  logic [15:0] total_d;
  logic        pen_d;
  logic        sink_d;

  // Analog-facing settings decoded from the fields
  always_comb begin
    // Doubler path ignores the pre-divider entirely
    if (input_doubler_select) begin
      in_ratio_d = `S2R_RATIO_ONE_7;
    end else if (stage2_predivider == `S2R_RATIO_ZERO_7) begin
      in_ratio_d = `S2R_RATIO_ONE_7; // Code zero has no ratio; treated as bypass
    end else begin
      in_ratio_d = stage2_predivider; // Binary ratio, one means bypass
    end
    vcxo_ratio_d = vcxo_feedback_halve_sel ? `S2R_RATIO_TWO_2 : `S2R_RATIO_ONE_2;
    extv_ratio_d = ext_vco_halve_sel ? `S2R_RATIO_TWO_2 : `S2R_RATIO_ONE_2;
    // Clock-input source only makes sense with the first loop bypassed
    src_valid_d = !((output_source_sel == S2R_SRC_CLK_INPUT) && !first_loop_bypass);
    // Gain current in 0.1 uA units
    if (stage2_pump_gain_double) begin
      gain_d = `S2R_BASE_2X_DUA
             + ({13'h0000, stage2_pump_gain_code[2:0]} * `S2R_STEP_2X_DUA);
    end else begin
      gain_d = {12'h000, stage2_pump_gain_code} * `S2R_STEP_1X_DUA;
    end
    // Offset is a weighted sum, not a plain binary code: two bits weigh 100 uA
    offs_d = (stage2_pump_offset_code[5] ? `S2R_OFFS_W5 : 6'h00)
           + (stage2_pump_offset_code[4] ? `S2R_OFFS_W4 : 6'h00)
           + (stage2_pump_offset_code[3] ? `S2R_OFFS_W3 : 6'h00)
           + (stage2_pump_offset_code[2] ? `S2R_OFFS_W2 : 6'h00)
           + (stage2_pump_offset_code[1] ? `S2R_OFFS_W1 : 6'h00)
           + (stage2_pump_offset_code[0] ? `S2R_OFFS_W0 : 6'h00);
    // Pump enables follow the power-down bit
    pen_d  = !stage2_pump_powerdown;
    sink_d = stage2_pump_sink_enable && !stage2_pump_powerdown;
    // A powered-down pump delivers nothing, offset included
    if (stage2_pump_powerdown) begin
      total_d = 16'h0000;
    end else begin
      total_d = gain_d + ({10'h000, offs_d} * `S2R_OFFS_STEP_DUA);
    end
  end

  // Outputs registered so the analog side sees glitch-free settings
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_INPUT_DOUBLE      <= `S2R_RST_DBL;
      O_INPUT_DIV_RATIO   <= `S2R_RST_PDIV;
      O_VCXO_FB_DIV_RATIO <= `S2R_RATIO_TWO_2;
      O_EXT_VCO_DIV_RATIO <= `S2R_RATIO_ONE_2;
      O_OUTPUT_SOURCE     <= `S2R_RST_SRC;
      O_SOURCE_VALID      <= 1'b1;
      O_FIRST_LOOP_BYPASS <= `S2R_RST_BYP;
      O_PUMP_ENABLE       <= 1'b1;
      O_PUMP_SINK_ENABLE  <= `S2R_RST_SINK;
      O_PUMP_GAIN_DUA     <= `S2R_BASE_2X_DUA;
      O_PUMP_OFFSET_STEPS <= `S2R_RST_OFFS;
      O_PUMP_TOTAL_DUA    <= `S2R_BASE_2X_DUA;
    end else begin
      O_INPUT_DOUBLE      <= input_doubler_select;
      O_INPUT_DIV_RATIO   <= in_ratio_d;
      O_VCXO_FB_DIV_RATIO <= vcxo_ratio_d;
      O_EXT_VCO_DIV_RATIO <= extv_ratio_d;
      O_OUTPUT_SOURCE     <= output_source_sel;
      O_SOURCE_VALID      <= src_valid_d;
      O_FIRST_LOOP_BYPASS <= first_loop_bypass;
      O_PUMP_ENABLE       <= pen_d;
      O_PUMP_SINK_ENABLE  <= sink_d;
      O_PUMP_GAIN_DUA     <= gain_d;
      O_PUMP_OFFSET_STEPS <= offs_d;
      O_PUMP_TOTAL_DUA    <= total_d;
    end
  end

  assign O_REG_RDATA  = rdata_q;
  assign O_REG_RVALID = rvalid_q;

endmodule // s2r_regs

/* File: testbench/s2r_regs_properties.sv */
`timescale 1ns/1ns
// Watches the register bank at its ports only
module s2r_regs_properties (
  input wire logic        I_CORE_CLK, I_RESET, I_REG_WR, I_REG_RD, O_REG_RVALID,
  input wire logic [7:0]  I_REG_ADDR, I_REG_WDATA, O_REG_RDATA,
  input wire logic        O_INPUT_DOUBLE, O_SOURCE_VALID, O_FIRST_LOOP_BYPASS,
  input wire logic        O_PUMP_ENABLE, O_PUMP_SINK_ENABLE,
  input wire logic [6:0]  O_INPUT_DIV_RATIO,
  input wire logic [1:0]  O_VCXO_FB_DIV_RATIO, O_EXT_VCO_DIV_RATIO, O_OUTPUT_SOURCE,
  input wire logic [5:0]  O_PUMP_OFFSET_STEPS,
  input wire logic [15:0] O_PUMP_GAIN_DUA, O_PUMP_TOTAL_DUA
);
  logic [7:0] wd1_q, wd2_q;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  // Write data delayed two edges lines up with the derived outputs
  always_ff @(posedge I_CORE_CLK) begin
    wd1_q <= I_REG_WDATA;
    wd2_q <= wd1_q;
  end

  // A write that is not overwritten on the next edge, so its effect can be judged
  sequence s_wr(logic [7:0] a);
    I_REG_WR && I_REG_ADDR == a ##1 !(I_REG_WR && I_REG_ADDR == a);
  endsequence

  a_unmapped_read: assert property (
    I_REG_RD && !(I_REG_ADDR inside {8'h20, 8'h21, 8'h28, 8'h29})
    |=> O_REG_RDATA == 8'h00 && O_REG_RVALID) else $error("Unmapped read gave data");
  a_resv_read: assert property (
    I_REG_RD && I_REG_ADDR == 8'h21 |=> O_REG_RDATA[2:0] == 3'h0)
    else $error("Reserved bits read nonzero");
  a_pump_off: assert property (
    !O_PUMP_ENABLE |-> O_PUMP_TOTAL_DUA == 16'h0000 && !O_PUMP_SINK_ENABLE)
    else $error("Powered down pump still drives");
  a_total_sum: assert property (
    O_PUMP_ENABLE |-> O_PUMP_TOTAL_DUA == O_PUMP_GAIN_DUA + 16'(O_PUMP_OFFSET_STEPS) * 16'h007D)
    else $error("Pump total is not gain plus offset");
  a_src_valid: assert property (
    O_SOURCE_VALID == !(O_OUTPUT_SOURCE == 2'h3 && !O_FIRST_LOOP_BYPASS))
    else $error("Source valid flag wrong");
  a_dbl_ratio: assert property (
    O_INPUT_DOUBLE |-> O_INPUT_DIV_RATIO == 7'h01) else $error("Divider active with doubler");
  a_prediv_wr: assert property (
    s_wr(8'h20) |=> O_INPUT_DOUBLE == wd2_q[7]
      && (wd2_q[7] || wd2_q[6:0] == 7'h00 || O_INPUT_DIV_RATIO == wd2_q[6:0]))
    else $error("Input path does not follow write");
  a_src_wr: assert property (
    s_wr(8'h21) |=> {O_VCXO_FB_DIV_RATIO, O_EXT_VCO_DIV_RATIO, O_OUTPUT_SOURCE,
      O_FIRST_LOOP_BYPASS} == {wd2_q[7], !wd2_q[7], wd2_q[6], !wd2_q[6], wd2_q[5:3]})
    else $error("Source and halving do not follow write");
  a_gain_wr: assert property (
    s_wr(8'h28) |=> O_PUMP_GAIN_DUA == (wd2_q[4] ? 16'h3E80 + 16'(wd2_q[2:0]) * 16'h07D0
      : 16'(wd2_q[3:0]) * 16'h03E8) && O_PUMP_ENABLE == !wd2_q[7]
      && O_PUMP_SINK_ENABLE == (wd2_q[5] && !wd2_q[7])) else $error("Pump gain wrong");
  a_offs_wr: assert property (
    s_wr(8'h29) |=> O_PUMP_OFFSET_STEPS == 6'({wd2_q[5], 1'b0, wd2_q[2:0]})
      + 6'({wd2_q[4], 3'h0}) + 6'({wd2_q[3], 3'h0})) else $error("Offset steps wrong");

  c_src_wr: cover property (s_wr(8'h21));
  c_pump_off: cover property (!O_PUMP_ENABLE);
  c_src_bad: cover property (!O_SOURCE_VALID);
endmodule // s2r_regs_properties

/* File: testbench/s2r_regs_tb_top.sv */
`timescale 1ns/1ns
// Table-driven bench for the stage-two register bank
module s2r_regs_tb_top;
  logic        clk, rst, wr, rd;
  logic [7:0]  addr, wdata, rdata, v;
  logic        rvalid, dbl, srcv, byp, pen, sink;
  logic [6:0]  ratio;
  logic [1:0]  vcxo, extv, src;
  logic [5:0]  steps;
  logic [15:0] gain, total;
  int          miscompares, total_checks;
  // Address, write data, readback, observed outputs
  logic [55:0] rows [17] = '{
    56'h20_7F_7F_0000007F, 56'h20_81_81_00000081, 56'h20_00_00_00000001,
    56'h20_01_01_00000001, 56'h21_FF_F8_000000AF, 56'h21_30_30_0000005C,
    56'h21_20_20_0000005A, 56'h21_00_00_00000052, 56'h21_10_10_00000056,
    56'h28_FF_BF_00000000, 56'h28_1F_1F_00027530, 56'h28_0F_0F_00023A98,
    56'h28_25_25_00031388, 56'h29_FF_3F_00272693, 56'h29_20_20_00101B58,
    56'h29_04_04_0004157C, 56'h30_FF_00_0004157C};
  logic [63:0] defaults = 64'h2001_2190_2830_2900;

  s2r_regs u_dut (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .O_INPUT_DOUBLE(dbl), .O_INPUT_DIV_RATIO(ratio), .O_VCXO_FB_DIV_RATIO(vcxo),
    .O_EXT_VCO_DIV_RATIO(extv), .O_OUTPUT_SOURCE(src), .O_SOURCE_VALID(srcv),
    .O_FIRST_LOOP_BYPASS(byp), .O_PUMP_ENABLE(pen), .O_PUMP_SINK_ENABLE(sink),
    .O_PUMP_GAIN_DUA(gain), .O_PUMP_OFFSET_STEPS(steps), .O_PUMP_TOTAL_DUA(total));

  // Outputs that a write to each register is meant to move
  function automatic logic [31:0] obs(input logic [7:0] a);
    case (a)
      8'h20: return {24'h0, dbl, ratio};
      8'h21: return {24'h0, vcxo, extv, src, srcv, byp};
      8'h28: return {14'h0, pen, sink, total};
      default: return {10'h0, steps, total};
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One-cycle strobes; derived outputs settle one edge after the write edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({31'h0, rvalid}, 32'h1);
    @(posedge clk);
    #1;
    v = rdata;
    chk({31'h0, rvalid}, 32'h0);
  endtask

  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    logic [55:0] r;
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 17; i++) begin
      r = rows[i];
      wr_reg(r[55:48], r[47:40]);
      rd_reg(r[55:48]);
      chk({24'h0, v}, {24'h0, r[39:32]});
      chk(obs(r[55:48]), r[31:0]);
    end
    // Write and read in one cycle: the read must see the old byte
    @(posedge clk);
    addr <= 8'h20;
    wdata <= 8'h55;
    wr <= 1'b1;
    rd <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    #1;
    chk({24'h0, rdata}, 32'h01);
    rd_reg(8'h20);
    chk({24'h0, v}, 32'h55);
    // A second reset in mid-run must restore every default
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({9'h0, dbl, steps, ratio, vcxo, extv, src, byp, pen, sink},
      {9'h0, 1'h0, 6'h00, 7'h01, 2'h2, 2'h1, 2'h1, 1'h0, 1'h1, 1'h1});
    chk({gain, total}, {16'h3E80, 16'h3E80});
    for (int i = 3; i >= 0; i--) begin
      rd_reg(defaults[i*16+8 +: 8]);
      chk({24'h0, v}, {24'h0, defaults[i*16 +: 8]});
    end
    finish_test();
  end

  // The whole run is about 120 cycles; 2000 means a hang
  initial begin
    #200000;
    miscompares++;
    finish_test();
  end
endmodule // s2r_regs_tb_top

bind s2r_regs s2r_regs_properties u_props (
  .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
  .O_REG_RVALID(O_REG_RVALID), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA), .O_INPUT_DOUBLE(O_INPUT_DOUBLE), .O_SOURCE_VALID(O_SOURCE_VALID),
  .O_FIRST_LOOP_BYPASS(O_FIRST_LOOP_BYPASS), .O_PUMP_ENABLE(O_PUMP_ENABLE),
  .O_PUMP_SINK_ENABLE(O_PUMP_SINK_ENABLE), .O_INPUT_DIV_RATIO(O_INPUT_DIV_RATIO),
  .O_VCXO_FB_DIV_RATIO(O_VCXO_FB_DIV_RATIO), .O_EXT_VCO_DIV_RATIO(O_EXT_VCO_DIV_RATIO),
  .O_OUTPUT_SOURCE(O_OUTPUT_SOURCE), .O_PUMP_OFFSET_STEPS(O_PUMP_OFFSET_STEPS),
  .O_PUMP_GAIN_DUA(O_PUMP_GAIN_DUA), .O_PUMP_TOTAL_DUA(O_PUMP_TOTAL_DUA));
